//--- tb/four_channel_memory_mover_tb.sv
// Bench of the four channel mover: AHB-Lite register traffic plus a memory model.
// Assumes the hand-over register map and zero wait state slave.
module four_channel_memory_mover_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        bus_own, mem_req, mem_we, mem_ack;
  logic [31:0] haddr, hwdata, hrdata, r, seed;
  logic [1:0]  htrans, dly;
  logic [2:0]  hsize;
  logic [15:0] trig_in;
  logic [23:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, e;
  int          err_count, comparisons, cyc, n;

  four_channel_memory_mover DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .trig_in(trig_in),
    .bus_own(bus_own), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  mover_mem_model mem0 (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .dly(dly), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Hang guard: far above the few hundred cycles the run needs
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Source byte that lands at destination offset i; odd channels walk downwards
  function automatic logic [11:0] src_of(input int c, input int i);
    return 12'(c[0] ? 32'h107 + c * 64 - i : 32'h100 + c * 64 + i);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite transfer; read data taken at the data phase edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    {hsel, hwrite, haddr, hwdata, htrans, trig_in, dly} = '0;
    hsize   = 3'h2;
    hresetn = 1'b0;
    seed    = 32'h089a5edf;
    for (int i = 0; i < 4096; i++)
    begin
      seed = xs(seed);
      mem0.mem[i] = seed[7:0];
    end
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values and an unmapped offset
    ahb(0, 32'h00, 0); chk(r, 0);
    chk({hreadyout, hresp}, 32'h2);
    ahb(0, 32'h88, 0); chk(r, 0);
    ahb(0, 32'h94, 0); chk(r, 0);
    // Each channel: own burst length, src mode, trigger line, answer speed
    for (int c = 0; c < 4; c++)
    begin
      dly <= 2'(c);
      ahb(1, c * 32 + 4, 8);
      ahb(1, c * 32 + 8, 1);
      ahb(1, c * 32 + 12, 32'(src_of(c, 0)));
      ahb(1, c * 32 + 16, 32'h400 + c * 64);
      ahb(1, c * 32, 32'h1 | c << 4 | (c[0] ? 2 : 1) << 6 | 1 << 8 | c << 10);
      trig_in <= 16'h1 << (c * 4 + c);
      n = 0;
      do begin ahb(0, 32'h84, 0); n++; end while (r[c] !== 1'b1 && n < 300);
      chk(r[c], 1);
      trig_in <= 16'h0;
      for (int i = 0; i < 8; i++)
      begin
        e = mem0.mem[src_of(c, i)];
        chk(mem0.mem[12'h400 + c * 64 + i], e);
      end
      // Block count spent, the single repeat still shows as the current one
      ahb(0, c * 32 + 28, 0); chk(r, 32'h0002_0000);
    end
    // Masked and unmasked completion interrupt, then write-one clear
    chk(irq, 0);
    ahb(1, 32'h88, 32'h1);
    repeat (3) @(posedge hclk);
    chk(irq, 1);
    ahb(1, 32'h84, 32'hf);
    repeat (3) @(posedge hclk);
    chk(irq, 0);
    ahb(0, 32'h84, 0); chk(r, 0);
    // Write into non-volatile space is refused with an error
    ahb(1, 32'h10, 32'h1000);
    ahb(1, 32'h88, 32'h10);
    ahb(1, 32'h00, 32'h3);
    repeat (40) @(posedge hclk);
    ahb(0, 32'h84, 0); chk(r, 32'h10);
    chk(irq, 1);
    ahb(0, 32'h00, 0); chk(r[0], 0);
    // Rotating priority, then channel 2: two blocks of two bytes, reload and link to 3
    ahb(1, 32'h80, 32'h1);
    ahb(0, 32'h80, 0); chk(r, 1);
    ahb(1, 32'h44, 2);
    ahb(1, 32'h48, 2);
    ahb(1, 32'h4c, 32'h200);
    ahb(1, 32'h50, 32'h600);
    ahb(1, 32'h40, 32'h17f);
    // Each block ends its burst, so the second block needs its own trigger
    repeat (60) @(posedge hclk);
    ahb(1, 32'h40, 32'h17f);
    repeat (3) @(posedge hclk);
    chk(bus_own, 1);
    n = 0;
    do begin ahb(0, 32'h84, 0); n++; end while (r[2] !== 1'b1 && n < 300);
    chk(r[2], 1);
    for (int i = 0; i < 4; i++)
      chk(mem0.mem[12'h600 + i], mem0.mem[12'h200 + i]);
    ahb(0, 32'h54, 0); chk(r, 32'h200);
    ahb(0, 32'h58, 0); chk(r, 32'h600);
    ahb(0, 32'h60, 0); chk(r[0], 1);
    chk(bus_own, 0);
    stop_test();
  end
endmodule // four_channel_memory_mover_tb

//--- tb/mover_mem_model.sv
// Byte memory standing on the shared data bus, answering the engine's requests.
// Assumes one engine master; only the low 12 address bits select a byte.
module mover_mem_model
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [1:0]  dly,        // Wait cycles before each acknowledge
  output logic [7:0]       mem_rdata,
  output logic             mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:4095];            // Storage, loaded by the bench
  logic [1:0] cnt;                     // Remaining wait cycles
  // Acknowledge one pulse per request; data line toggles when not answering
  // Plain always: the bench preloads the storage from its own process
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      mem_ack   <= 1'b0;
      cnt       <= 2'h0;
      mem_rdata <= 8'h00;
    end
    else
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;          // Stale value never looks valid
      if (mem_req && !mem_ack)
      begin
        if (cnt == 2'h0)
        begin
          mem_ack   <= 1'b1;
          cnt       <= dly;
          mem_rdata <= mem[mem_addr[11:0]];
          if (mem_we)
            mem[mem_addr[11:0]] <= mem_wdata;
        end
        else
          cnt <= cnt - 2'h1;            // Slow answer
      end
    end
endmodule // mover_mem_model

//--- verilog/channel_arbiter.sv
// Picks one requesting channel, fixed or rotating priority.
// Assumes take is pulsed only in a cycle where grant_valid is high.
module channel_arbiter
(
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic [mover_pkg::NCH-1:0]     req,          // Channels ready for a burst
  input  wire logic                          round_robin,  // Rotating when high, else channel 0 first
  input  wire logic                          take,         // Grant accepted this cycle
  output logic                               grant_valid,
  output logic [1:0]                         grant_idx
);

  logic [1:0] last;  // Channel served most recently

  // Lowest candidate wins; rotating mode starts just after the last one served
  always_comb
  begin
    logic [1:0] cand;
    cand        = 2'h0;
    grant_valid = 1'b0;
    grant_idx   = 2'h0;
    for (int k = mover_pkg::NCH - 1; k >= 0; k--)
    begin
      cand = round_robin ? 2'(last + 2'h1 + 2'(k)) : 2'(k);
      if (req[cand])
      begin
        grant_valid = 1'b1;
        grant_idx   = cand;
      end
    end
  end

  // Remember who was served so rotation moves on
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      last <= 2'h3;
    else if (take)
      last <= grant_idx;
  end

  a_grant_requested: assert property (@(posedge hclk) disable iff (!hresetn)
    grant_valid |-> req[grant_idx]) else $error("grant to idle channel");
  a_fixed_lowest: assert property (@(posedge hclk) disable iff (!hresetn)
    grant_valid && !round_robin |-> (req & ((4'h1 << grant_idx) - 4'h1)) == 4'h0)
    else $error("fixed priority skipped a lower channel");

endmodule // channel_arbiter

//--- verilog/four_channel_memory_mover.sv
// Four channel memory mover: AHB-Lite register slave plus a byte master on the shared data bus.
// Assumes mem_ack is a one-cycle pulse given only while mem_req is high, and that the
// processor honours bus_own by holding its own data accesses.
module four_channel_memory_mover
#(
  parameter int TRIG_W = 4  // Trigger lines per channel
)
(
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  input  wire logic                                 hsel,
  input  wire logic [31:0]                          haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic                                      hreadyout,
  output logic [31:0]                               hrdata,
  output logic                                      hresp,
  output logic                                      irq,
  input  wire logic [mover_pkg::NCH*TRIG_W-1:0]     trig_in,
  output logic                                      bus_own,
  output logic                                      mem_req,
  output logic                                      mem_we,
  output logic [mover_pkg::AW-1:0]                  mem_addr,
  output logic [7:0]                                mem_wdata,
  input  wire logic [7:0]                           mem_rdata,
  input  wire logic                                 mem_ack
);

  localparam int NCH = mover_pkg::NCH;
  localparam int AW  = mover_pkg::AW;

  // Trigger select is two bits wide, so more than four lines cannot be reached
  if (TRIG_W < 1 || TRIG_W > 4) begin : g_bad_trig
    $error("TRIG_W must be 1 to 4");
  end

  // Per-channel configuration and working state
  logic [mover_pkg::CTRL_W-1:0] ctrl     [NCH];  // Control fields
  logic [15:0]                  blk      [NCH];  // Block size, 0 means 64K
  logic [7:0]                   rep      [NCH];  // Repeat count, 0 means 256
  logic [AW-1:0]                src_base [NCH];  // Programmed source
  logic [AW-1:0]                dst_base [NCH];  // Programmed destination
  logic [AW-1:0]                src_cur  [NCH];  // Running source
  logic [AW-1:0]                dst_cur  [NCH];  // Running destination
  logic [16:0]                  blk_left [NCH];  // Bytes left in this block
  logic [8:0]                   rep_left [NCH];  // Blocks left including this one
  logic [NCH-1:0]               pend;            // Burst requested by a trigger

  // Global registers
  logic [7:0]                   stat;            // Error in 7:4, done in 3:0
  logic [7:0]                   mask;            // Interrupt enables, same layout
  logic                         prio_rr;         // Rotating priority when set

  // Engine state
  mover_pkg::mover_state_t      st;
  logic [1:0]                   act;             // Channel owning the bus
  logic [3:0]                   burst_cnt;       // Bytes done in this burst
  logic [7:0]                   data_byte;       // Byte between read and write

  // Bus address phase captured for the data phase write
  logic                         ap_wr;
  logic [7:0]                   ap_addr;
  logic                         ap_low;          // Upper address bits were zero

  // Address phase decode
  wire        ap_take  = hsel & hready & htrans[1];
  wire        rd_low   = haddr[31:8] == 24'h0;
  wire        wr_ch    = ap_wr & ap_low & ~ap_addr[7];
  wire        wr_gl    = ap_wr & ap_low & ap_addr[7];
  wire [1:0]  wr_sel   = ap_addr[6:5];
  wire [4:0]  wr_off   = ap_addr[4:0];
  wire        w_stat   = wr_gl & (ap_addr == mover_pkg::OFS_STATUS);
  wire        w_mask   = wr_gl & (ap_addr == mover_pkg::OFS_MASK);
  wire        w_prio   = wr_gl & (ap_addr == mover_pkg::OFS_PRIO);

  // Engine decode on the active channel
  wire [1:0]  a_smode   = ctrl[act][mover_pkg::F_SMODE +: 2];
  wire [1:0]  a_dmode   = ctrl[act][mover_pkg::F_DMODE +: 2];
  wire        byte_done = (st == mover_pkg::ST_WRITE) & mem_req & mem_ack;
  wire        last_byte = blk_left[act] == 17'h1;
  wire        last_rep  = rep_left[act] == 9'h1;
  wire        finish    = byte_done & last_byte & last_rep;
  wire [3:0]  burst_len = mover_pkg::burst_bytes(ctrl[act][mover_pkg::F_BURST +: 2]);
  wire        burst_end = byte_done & (last_byte | (burst_cnt + 4'h1 == burst_len));
  wire        bad_src   = mover_pkg::flash_hit(src_cur[act]);
  wire        bad_dst   = mover_pkg::flash_hit(dst_cur[act]) | mover_pkg::nvm_hit(dst_cur[act]);
  wire        abort     = ~mem_req & (((st == mover_pkg::ST_READ) & bad_src) |
                                      ((st == mover_pkg::ST_WRITE) & bad_dst));
  wire [3:0]  act_bit   = 4'h1 << act;
  wire [3:0]  done_vec  = finish ? act_bit : 4'h0;
  wire [3:0]  err_vec   = abort ? act_bit : 4'h0;
  wire [1:0]  partner   = act ^ 2'h1;

  // Trigger selection and arbitration
  wire [NCH-1:0] trig_line;
  wire [NCH-1:0] sw_trig;
  wire [NCH-1:0] en_vec;
  wire           grant_valid;
  wire [1:0]     grant_idx;
  wire           take = (st == mover_pkg::ST_IDLE) & grant_valid;

  for (genvar c = 0; c < NCH; c++) begin : g_trig
    wire [1:0] tsel = ctrl[c][mover_pkg::F_TSEL +: 2];
    assign trig_line[c] = (32'(tsel) < TRIG_W) & trig_in[c*TRIG_W + 32'(tsel)];
    assign sw_trig[c]   = wr_ch & (wr_sel == 2'(c)) & (wr_off == mover_pkg::OFS_CTRL)
                        & hwdata[mover_pkg::F_SWTRIG];
    assign en_vec[c]    = ctrl[c][mover_pkg::F_EN];
  end

  channel_arbiter u_arb
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .req         (pend & en_vec),
    .round_robin (prio_rr),
    .take        (take),
    .grant_valid (grant_valid),
    .grant_idx   (grant_idx)
  );

  // Register read value for the address phase now on the bus
  logic [31:0] rv;
  always_comb
  begin
    rv = 32'h0;
    if (rd_low && !haddr[7])
    begin
      unique case (haddr[4:0])
        mover_pkg::OFS_CTRL:    rv = 32'(ctrl[haddr[6:5]]);
        mover_pkg::OFS_BLOCK:   rv = 32'(blk[haddr[6:5]]);
        mover_pkg::OFS_REPEAT:  rv = 32'(rep[haddr[6:5]]);
        mover_pkg::OFS_SRC:     rv = 32'(src_base[haddr[6:5]]);
        mover_pkg::OFS_DST:     rv = 32'(dst_base[haddr[6:5]]);
        mover_pkg::OFS_CUR_SRC: rv = 32'(src_cur[haddr[6:5]]);
        mover_pkg::OFS_CUR_DST: rv = 32'(dst_cur[haddr[6:5]]);
        mover_pkg::OFS_LEFT:    rv = {6'h0, rep_left[haddr[6:5]], blk_left[haddr[6:5]]};
        default:                rv = 32'h0;  // Unmapped words read zero
      endcase
    end
    else if (rd_low)
    begin
      unique case (haddr[7:0])
        mover_pkg::OFS_PRIO:   rv = {31'h0, prio_rr};
        mover_pkg::OFS_STATUS: rv = {24'h0, stat};
        mover_pkg::OFS_MASK:   rv = {24'h0, mask};
        mover_pkg::OFS_BUSY:   rv = {26'h0, act, 3'h0, st != mover_pkg::ST_IDLE};
        default:               rv = 32'h0;
      endcase
    end
  end

  // Bus slave: zero wait, read data registered from the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      ap_wr     <= 1'b0;
      ap_addr   <= 8'h0;
      ap_low    <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= (ap_take & ~hwrite) ? rv : 32'h0;
      ap_wr     <= ap_take & hwrite;
      ap_addr   <= haddr[7:0];
      ap_low    <= rd_low;
    end
  end

  // Global registers; a hardware set beats a same-cycle write-one clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stat    <= 8'h0;
      mask    <= mover_pkg::MASK_RST;
      prio_rr <= 1'b0;
      irq     <= 1'b0;
    end
    else
    begin
      stat <= (stat & ~(w_stat ? hwdata[7:0] : 8'h0)) | {err_vec, done_vec};
      if (w_mask)
        mask <= hwdata[7:0];
      if (w_prio)
        prio_rr <= hwdata[0];
      irq <= |(stat & mask);
    end
  end

  // Channel registers: bus writes first, engine updates override in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        ctrl[c]     <= mover_pkg::CTRL_RST;
        blk[c]      <= 16'h0;
        rep[c]      <= 8'h0;
        src_base[c] <= '0;
        dst_base[c] <= '0;
        src_cur[c]  <= '0;
        dst_cur[c]  <= '0;
        blk_left[c] <= '0;
        rep_left[c] <= '0;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        // Trigger sets pending, burst end or abort clears it; set wins
        pend[c] <= (pend[c] & en_vec[c] & ~((burst_end | abort) & (act == 2'(c))))
                 | sw_trig[c] | (en_vec[c] & trig_line[c]);
        if (wr_ch && wr_sel == 2'(c))
        begin
          unique case (wr_off)
            mover_pkg::OFS_CTRL:
            begin
              ctrl[c] <= hwdata[mover_pkg::CTRL_W-1:0] & ~12'(1 << mover_pkg::F_SWTRIG);
              if (hwdata[mover_pkg::F_EN] && !en_vec[c])
              begin
                src_cur[c]  <= src_base[c];
                dst_cur[c]  <= dst_base[c];
                blk_left[c] <= {blk[c] == 16'h0, blk[c]};
                rep_left[c] <= {rep[c] == 8'h0, rep[c]};
              end
            end
            mover_pkg::OFS_BLOCK:  blk[c]      <= hwdata[15:0];
            mover_pkg::OFS_REPEAT: rep[c]      <= hwdata[7:0];
            mover_pkg::OFS_SRC:    src_base[c] <= hwdata[AW-1:0];
            mover_pkg::OFS_DST:    dst_base[c] <= hwdata[AW-1:0];
            default:               ;  // Read-only or unmapped words ignore writes
          endcase
        end
        // Partner of a finishing linked channel takes over
        if (finish && ctrl[act][mover_pkg::F_LINK] && partner == 2'(c))
        begin
          ctrl[c][mover_pkg::F_EN] <= 1'b1;
          src_cur[c]  <= src_base[c];
          dst_cur[c]  <= dst_base[c];
          blk_left[c] <= {blk[c] == 16'h0, blk[c]};
          rep_left[c] <= {rep[c] == 8'h0, rep[c]};
        end
      end
      // Illegal address stops the channel
      if (abort)
        ctrl[act][mover_pkg::F_EN] <= 1'b0;
      if (byte_done)
      begin
        src_cur[act]  <= mover_pkg::step_addr(src_cur[act], a_smode);
        dst_cur[act]  <= mover_pkg::step_addr(dst_cur[act], a_dmode);
        blk_left[act] <= blk_left[act] - 17'h1;
        if (last_byte && !last_rep)
        begin
          blk_left[act] <= {blk[act] == 16'h0, blk[act]};
          rep_left[act] <= rep_left[act] - 9'h1;
        end
        if (finish)
        begin
          ctrl[act][mover_pkg::F_EN] <= 1'b0;
          if (ctrl[act][mover_pkg::F_RELOAD])
          begin
            src_cur[act] <= src_base[act];
            dst_cur[act] <= dst_base[act];
          end
        end
      end
    end
  end

  // Bus master engine: one byte read then written, repeated for the burst
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st        <= mover_pkg::ST_IDLE;
      act       <= 2'h0;
      burst_cnt <= 4'h0;
      data_byte <= 8'h0;
      bus_own   <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= 8'h0;
    end
    else
    begin
      unique case (st)
        mover_pkg::ST_IDLE:
        begin
          if (take)
          begin
            act       <= grant_idx;
            st        <= mover_pkg::ST_READ;
            bus_own   <= 1'b1;
            burst_cnt <= 4'h0;
          end
        end
        mover_pkg::ST_READ:
        begin
          if (abort)
          begin
            st      <= mover_pkg::ST_IDLE;
            bus_own <= 1'b0;
          end
          else if (!mem_req)
          begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= src_cur[act];
          end
          else if (mem_ack)
          begin
            mem_req   <= 1'b0;
            data_byte <= mem_rdata;
            st        <= mover_pkg::ST_WRITE;
          end
        end
        mover_pkg::ST_WRITE:
        begin
          if (abort)
          begin
            st      <= mover_pkg::ST_IDLE;
            bus_own <= 1'b0;
          end
          else if (!mem_req)
          begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= dst_cur[act];
            mem_wdata <= data_byte;
          end
          else if (mem_ack)
          begin
            mem_req   <= 1'b0;
            burst_cnt <= burst_cnt + 4'h1;
            st        <= burst_end ? mover_pkg::ST_IDLE : mover_pkg::ST_READ;
            bus_own   <= ~burst_end;
          end
        end
      endcase
    end
  end

  a_nvm_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_req && mem_we |-> !mover_pkg::nvm_hit(mem_addr)) else $error("write into nvm");
  a_flash_never: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_req |-> !mover_pkg::flash_hit(mem_addr)) else $error("flash accessed");
  a_bus_owned: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_req |-> bus_own ##0 st != mover_pkg::ST_IDLE) else $error("access without bus");
  a_burst_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    st == mover_pkg::ST_WRITE |-> burst_cnt < burst_len) else $error("burst too long");
  a_done_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    finish |=> stat[$past(act)] && !ctrl[$past(act)][mover_pkg::F_EN]) else $error("done missing");
  a_reload_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    finish && ctrl[act][mover_pkg::F_RELOAD] |=> src_cur[$past(act)] == src_base[$past(act)]
    && dst_cur[$past(act)] == dst_base[$past(act)]) else $error("no reload");
  a_link_start: assert property (@(posedge hclk) disable iff (!hresetn)
    finish && ctrl[act][mover_pkg::F_LINK] |=> ctrl[$past(partner)][mover_pkg::F_EN])
    else $error("partner not started");
  a_src_step: assert property (@(posedge hclk) disable iff (!hresetn)
    byte_done && !finish && a_smode == mover_pkg::AM_INC && !wr_ch
    |=> src_cur[$past(act)] == $past(src_cur[act]) + 24'h1) else $error("source step");
  a_bus_release: assert property (@(posedge hclk) disable iff (!hresetn)
    burst_end |=> !bus_own ##1 !mem_req) else $error("bus kept after burst");

endmodule // four_channel_memory_mover

//--- verilog/mover_pkg.sv
// Constants, field layout, states and helper functions of the four channel memory mover.
// Assumes a 24-bit byte-addressed data space shared with the processor and an AHB-Lite register port.
package mover_pkg;

  localparam int NCH     = 4;           // Channel count
  localparam int AW      = 24;          // Data space address width
  localparam int CTRL_W  = 12;          // Stored control bits per channel

  // Per-channel register offsets, channel n sits at n * 0x20
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_BLOCK   = 5'h04;
  localparam logic [4:0] OFS_REPEAT  = 5'h08;
  localparam logic [4:0] OFS_SRC     = 5'h0c;
  localparam logic [4:0] OFS_DST     = 5'h10;
  localparam logic [4:0] OFS_CUR_SRC = 5'h14;
  localparam logic [4:0] OFS_CUR_DST = 5'h18;
  localparam logic [4:0] OFS_LEFT    = 5'h1c;

  // Global register offsets
  localparam logic [7:0] OFS_PRIO    = 8'h80;
  localparam logic [7:0] OFS_STATUS  = 8'h84;
  localparam logic [7:0] OFS_MASK    = 8'h88;
  localparam logic [7:0] OFS_BUSY    = 8'h8c;

  // Control field positions
  localparam int F_EN     = 0;          // Channel enable
  localparam int F_SWTRIG = 1;          // Software trigger, write only
  localparam int F_RELOAD = 2;          // Restore addresses at completion
  localparam int F_LINK   = 3;          // Start partner channel at completion
  localparam int F_BURST  = 4;          // Two bits, burst of 1 << value bytes
  localparam int F_SMODE  = 6;          // Two bits, source address mode
  localparam int F_DMODE  = 8;          // Two bits, destination address mode
  localparam int F_TSEL   = 10;         // Two bits, trigger line select

  // Address modes
  localparam logic [1:0] AM_FIXED = 2'h0;
  localparam logic [1:0] AM_INC   = 2'h1;
  localparam logic [1:0] AM_DEC   = 2'h2;

  // Memory regions guarded by the engine
  localparam logic [AW-1:0] NVM_LO   = 24'h001000;
  localparam logic [AW-1:0] NVM_HI   = 24'h001fff;
  localparam logic [AW-1:0] FLASH_LO = 24'h800000;
  localparam logic [AW-1:0] FLASH_HI = 24'hffffff;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [7:0]        MASK_RST = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b11
  } mover_state_t;

  // Next address after one byte
  function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a, input logic [1:0] mode);
    step_addr = (mode == AM_INC) ? a + 24'h1 : (mode == AM_DEC) ? a - 24'h1 : a;
  endfunction

  // Bytes in one burst
  function automatic logic [3:0] burst_bytes(input logic [1:0] sel);
    burst_bytes = 4'h1 << sel;
  endfunction

  function automatic logic nvm_hit(input logic [AW-1:0] a);
    nvm_hit = (a >= NVM_LO) && (a <= NVM_HI);
  endfunction

  function automatic logic flash_hit(input logic [AW-1:0] a);
    flash_hit = (a >= FLASH_LO) && (a <= FLASH_HI);
  endfunction

endpackage
